// file: rtl/hsc_consts.svh
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

// register byte offsets on the avalon slave
`define HSC_OFF_CTRL 5'h00
`define HSC_OFF_CMD 5'h04
`define HSC_OFF_STATUS 5'h08
`define HSC_OFF_SIZE 5'h0C
`define HSC_OFF_OVL_PIX 5'h10
`define HSC_OFF_OVL_LINE 5'h14
`define HSC_OFF_ALPHA 5'h18
`define HSC_OFF_POS 5'h1C

// command bits
`define HSC_CMD_START 0
`define HSC_CMD_ABORT 1

// status bits
`define HSC_ST_BUSY 0
`define HSC_ST_STALLED 1
`define HSC_ST_RESERVED 2

// reset values
`define HSC_CTRL_RST 16'h0000
`define HSC_SIZE_RST 16'h0000
`define HSC_ALPHA_RST 16'h0000

// output and overlay format codes
`define HSC_FMT_RGB_FIRST 4'h2
`define HSC_FMT_RGB_LAST 4'h7
`define HSC_OVL_FMT_RSVD 2'h3
`define HSC_OVL_FMT_RGB15A 2'h1
`define HSC_OVL_FMT_YUVA 2'h2

// component cycles spent per pair of output pixels
`define HSC_CYC_PAIR_NORMAL 3'h6
`define HSC_CYC_PAIR_SEQ 3'h4

`endif

// file: rtl/hsc_pkg.sv
package hsc_pkg;

  typedef enum logic [1:0] {HSC_COMP_U, HSC_COMP_V, HSC_COMP_Y} hsc_comp_t;

  typedef enum logic {HSC_IDLE, HSC_RUN} hsc_state_t;

  // control word, bit 15 down to bit 0
  typedef struct packed {
    logic bypass;
    logic chroma_pair_sequencing;
    logic chroma_half_vertical_in;
    logic overlay_on;
    logic pci_out;
    logic mask_bits_on;
    logic pick_then_filter;
    logic overlay_byte_order;
    logic [1:0] overlay_pixel_format;
    logic color_key_on;
    logic output_byte_order;
    logic [3:0] out_fmt;
  } hsc_ctl_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } hsc_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } hsc_av_rsp_t;

  typedef struct packed {
    logic comp_valid;
    hsc_comp_t comp_sel;
    logic pix_strobe;
    logic line_end;
    logic uv_refresh;
    logic uv_upscale2;
    logic [15:0] out_pix;
    logic [15:0] out_line;
    logic [15:0] chroma_line;
    logic filter_bypass;
    logic tap_from_output;
    logic frac_lsb_zero;
    logic out_to_pci;
    logic blend_on;
    logic mask_on;
    logic ckey_on;
    logic alpha_active;
    logic [7:0] alpha1;
    logic [7:0] alpha0;
    logic ovl_le;
    logic out_le;
    logic [1:0] ovl_fmt;
    logic [3:0] out_fmt;
    logic fmt_reserved;
    logic stalled;
    logic busy;
    logic frame_done;
  } hsc_px_t;

  typedef struct packed {
    hsc_ctl_t ctl;
    hsc_ctl_t run;
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] ovl_spix;
    logic [15:0] ovl_epix;
    logic [15:0] ovl_sline;
    logic [15:0] ovl_eline;
    logic [15:0] alpha;
    hsc_state_t state;
    logic [1:0] phase;
    logic [15:0] pix;
    logic [15:0] line;
    logic permit_s1;
    logic permit_s2;
    logic [2:0] pair_cnt;
    hsc_av_rsp_t rsp;
    hsc_px_t px;
  } hsc_regs_t;

endpackage

// file: rtl/hsc_scaler_ctl.sv
`timescale 1ns/10ps
`include "hsc_consts.svh"

module hsc_scaler_ctl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire hsc_pkg::hsc_av_req_t av_req,
  output hsc_pkg::hsc_av_rsp_t av_rsp,
  input wire logic coproc_dma_permit,
  output hsc_pkg::hsc_px_t px
);

  hsc_pkg::hsc_regs_t s_reg;
  hsc_pkg::hsc_regs_t s_next;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic rgb_fmt;
  logic rgb_pci;
  logic go;
  logic in_win;
  logic last_pix;
  logic last_line;
  logic [31:0] rd_val;
  logic [31:0] wmerge;

  always_comb begin
    rgb_fmt = (s_reg.run.out_fmt >= `HSC_FMT_RGB_FIRST) && (s_reg.run.out_fmt <= `HSC_FMT_RGB_LAST);
    // RGB to PCI waits on the host's DMA permission
    rgb_pci = s_reg.run.pci_out && rgb_fmt;
    go = (s_reg.state == hsc_pkg::HSC_RUN) && !(rgb_pci && !s_reg.permit_s2);
    in_win = (s_reg.pix >= s_reg.ovl_spix) && (s_reg.pix <= s_reg.ovl_epix)
          && (s_reg.line >= s_reg.ovl_sline) && (s_reg.line <= s_reg.ovl_eline);
    last_pix = (s_reg.pix == s_reg.width - 16'h0001);
    last_line = (s_reg.line == s_reg.height - 16'h0001);
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (av_req.address)
      `HSC_OFF_CTRL: rd_val = {16'h0000, s_reg.ctl};
      `HSC_OFF_STATUS: begin
        rd_val[`HSC_ST_BUSY] = (s_reg.state == hsc_pkg::HSC_RUN);
        rd_val[`HSC_ST_STALLED] = s_reg.px.stalled;
        rd_val[`HSC_ST_RESERVED] = s_reg.px.fmt_reserved;
      end
      `HSC_OFF_SIZE: rd_val = {s_reg.height, s_reg.width};
      `HSC_OFF_OVL_PIX: rd_val = {s_reg.ovl_epix, s_reg.ovl_spix};
      `HSC_OFF_OVL_LINE: rd_val = {s_reg.ovl_eline, s_reg.ovl_sline};
      `HSC_OFF_ALPHA: rd_val = {16'h0000, s_reg.alpha};
      `HSC_OFF_POS: rd_val = {s_reg.line, s_reg.pix};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    wmerge = be_merge(rd_val, av_req.writedata, av_req.byteenable);
    s_next = s_reg;
    // pin crossing: first stage feeds only the second
    s_next.permit_s1 = coproc_dma_permit;
    s_next.permit_s2 = s_reg.permit_s1;

    // avalon slave: one wait cycle, then the answer
    s_next.rsp.waitrequest = 1'b1;
    if ((av_req.read || av_req.write) && s_reg.rsp.waitrequest) begin
      s_next.rsp.waitrequest = 1'b0;
      s_next.rsp.readdata = rd_val;
    end

    // one-cycle outputs fall back each cycle
    s_next.px.comp_valid = 1'b0;
    s_next.px.pix_strobe = 1'b0;
    s_next.px.line_end = 1'b0;
    s_next.px.uv_refresh = 1'b0;
    s_next.px.frame_done = 1'b0;
    s_next.px.stalled = (s_reg.state == hsc_pkg::HSC_RUN) && !go;
    s_next.px.busy = (s_reg.state == hsc_pkg::HSC_RUN);

    // helper count of component cycles per pixel pair
    // cleared after an odd pixel or a line end, so a short line never leaks into the next pair
    if (s_reg.px.pix_strobe && (s_reg.px.out_pix[0] || s_reg.px.line_end)) begin
      s_next.pair_cnt = 3'h0;
    end

    // static decode of the latched control word
    s_next.px.filter_bypass = s_reg.run.bypass;
    s_next.px.tap_from_output = s_reg.run.pick_then_filter && !s_reg.run.bypass;
    s_next.px.frac_lsb_zero = s_reg.run.pick_then_filter && !s_reg.run.bypass;
    s_next.px.uv_upscale2 = rgb_fmt && !s_reg.run.chroma_pair_sequencing && !s_reg.run.bypass;
    s_next.px.out_to_pci = s_reg.run.pci_out;
    s_next.px.mask_on = s_reg.run.mask_bits_on && s_reg.run.pci_out;
    s_next.px.ovl_le = s_reg.run.overlay_byte_order;
    s_next.px.out_le = s_reg.run.output_byte_order;
    s_next.px.ovl_fmt = s_reg.run.overlay_pixel_format;
    s_next.px.out_fmt = s_reg.run.out_fmt;
    s_next.px.fmt_reserved = (s_reg.run.out_fmt > `HSC_FMT_RGB_LAST)
                          || (s_reg.run.overlay_pixel_format == `HSC_OVL_FMT_RSVD);

    if (go) begin
      s_next.pair_cnt = s_next.pair_cnt + 3'h1;
      s_next.px.comp_valid = 1'b1;
      s_next.px.out_pix = s_reg.pix;
      s_next.px.out_line = s_reg.line;
      // 4:2:0 input: each chroma line serves two output lines
      s_next.px.chroma_line = s_reg.run.chroma_half_vertical_in ? {1'b0, s_reg.line[15:1]} : s_reg.line;
      s_next.px.blend_on = s_reg.run.overlay_on && s_reg.run.pci_out && in_win;
      s_next.px.ckey_on = s_reg.run.overlay_on && s_reg.run.pci_out && in_win && s_reg.run.color_key_on;
      s_next.px.alpha_active = s_reg.run.overlay_on && s_reg.run.pci_out && in_win
                            && ((s_reg.run.overlay_pixel_format == `HSC_OVL_FMT_RGB15A)
                            || (s_reg.run.overlay_pixel_format == `HSC_OVL_FMT_YUVA));
      if (s_reg.run.bypass) begin
        s_next.px.comp_sel = hsc_pkg::HSC_COMP_Y;
        s_next.px.pix_strobe = 1'b1;
      end else begin
        case (s_reg.phase)
          2'h0: begin
            s_next.px.comp_sel = hsc_pkg::HSC_COMP_U;
            s_next.px.uv_refresh = 1'b1;
            s_next.phase = 2'h1;
          end
          2'h1: begin
            s_next.px.comp_sel = hsc_pkg::HSC_COMP_V;
            s_next.phase = 2'h2;
          end
          2'h2: begin
            s_next.px.comp_sel = hsc_pkg::HSC_COMP_Y;
            s_next.px.pix_strobe = 1'b1;
            // paired mode adds a second Y unless the line ends here
            s_next.phase = (s_reg.run.chroma_pair_sequencing && !last_pix) ? 2'h3 : 2'h0;
          end
          default: begin
            s_next.px.comp_sel = hsc_pkg::HSC_COMP_Y;
            s_next.px.pix_strobe = 1'b1;
            s_next.phase = 2'h0;
          end
        endcase
      end
      if (s_next.px.pix_strobe) begin
        s_next.pix = s_reg.pix + 16'h0001;
        if (last_pix) begin
          s_next.px.line_end = 1'b1;
          s_next.pix = 16'h0000;
          s_next.phase = 2'h0;
          s_next.line = s_reg.line + 16'h0001;
          if (last_line) begin
            s_next.state = hsc_pkg::HSC_IDLE;
            s_next.px.frame_done = 1'b1;
          end
        end
      end
    end

    // register writes take effect at the edge where waitrequest is low
    if (av_req.write && !s_reg.rsp.waitrequest) begin
      case (av_req.address)
        `HSC_OFF_CTRL: s_next.ctl = hsc_pkg::hsc_ctl_t'(wmerge[15:0]);
        `HSC_OFF_SIZE: {s_next.height, s_next.width} = wmerge;
        `HSC_OFF_OVL_PIX: {s_next.ovl_epix, s_next.ovl_spix} = wmerge;
        `HSC_OFF_OVL_LINE: {s_next.ovl_eline, s_next.ovl_sline} = wmerge;
        `HSC_OFF_ALPHA: s_next.alpha = wmerge[15:0];
        `HSC_OFF_CMD: begin
          if (av_req.writedata[`HSC_CMD_ABORT] && av_req.byteenable[0]) begin
            s_next.state = hsc_pkg::HSC_IDLE;
          end else if (av_req.writedata[`HSC_CMD_START] && av_req.byteenable[0]
                       && (s_reg.state == hsc_pkg::HSC_IDLE)) begin
            // control word and alphas are frozen for the whole frame
            s_next.run = s_reg.ctl;
            s_next.px.alpha1 = s_reg.alpha[15:8];
            s_next.px.alpha0 = s_reg.alpha[7:0];
            s_next.pix = 16'h0000;
            s_next.line = 16'h0000;
            s_next.phase = 2'h0;
            s_next.pair_cnt = 3'h0;
            if ((s_reg.width == 16'h0000) || (s_reg.height == 16'h0000)) begin
              s_next.px.frame_done = 1'b1;
            end else begin
              s_next.state = hsc_pkg::HSC_RUN;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ctl <= `HSC_CTRL_RST;
      s_reg.run <= `HSC_CTRL_RST;
      s_reg.width <= `HSC_SIZE_RST;
      s_reg.height <= `HSC_SIZE_RST;
      s_reg.alpha <= `HSC_ALPHA_RST;
      s_reg.state <= hsc_pkg::HSC_IDLE;
      s_reg.rsp.waitrequest <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign av_rsp = s_reg.rsp;
  assign px = s_reg.px;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_u_out;
    px.comp_valid && (px.comp_sel == hsc_pkg::HSC_COMP_U);
  endsequence

  sequence s_v_out;
    px.comp_valid && (px.comp_sel == hsc_pkg::HSC_COMP_V);
  endsequence

  sequence s_y_even_paired;
    px.comp_valid && (px.comp_sel == hsc_pkg::HSC_COMP_Y) && !px.out_pix[0]
      && s_reg.run.chroma_pair_sequencing && !px.line_end && !px.filter_bypass;
  endsequence

  a_bypass_moves_y: assert property (px.comp_valid && px.filter_bypass |-> px.pix_strobe
    && (px.comp_sel == hsc_pkg::HSC_COMP_Y) && !px.tap_from_output)
    else $error("bypass cycle is not a plain pixel move");

  a_u_then_v: assert property (s_u_out ##1 px.comp_valid |-> px.comp_sel == hsc_pkg::HSC_COMP_V)
    else $error("component after U is not V");

  a_v_then_y: assert property (s_v_out ##1 px.comp_valid |->
    px.comp_sel == hsc_pkg::HSC_COMP_Y && px.pix_strobe)
    else $error("component after V is not a Y pixel");

  a_paired_second_y: assert property (s_y_even_paired ##1 px.comp_valid |->
    px.comp_sel == hsc_pkg::HSC_COMP_Y && px.out_pix[0])
    else $error("paired mode lacks second Y");

  a_uv_every_second: assert property (px.uv_refresh && s_reg.run.chroma_pair_sequencing |->
    !px.out_pix[0] && !px.uv_upscale2)
    else $error("chroma refreshed on odd pixel in paired mode");

  a_pair_cycle_count: assert property (px.pix_strobe && px.out_pix[0] && !px.filter_bypass |->
    s_reg.pair_cnt == (s_reg.run.chroma_pair_sequencing ? `HSC_CYC_PAIR_SEQ : `HSC_CYC_PAIR_NORMAL))
    else $error("wrong cycle count per pixel pair");

  a_chroma_line_dup: assert property (px.comp_valid && s_reg.run.chroma_half_vertical_in |->
    px.chroma_line == {1'b0, px.out_line[15:1]})
    else $error("chroma line not shared by line pair");

  a_blend_pci_window: assert property (px.blend_on && px.comp_valid |-> px.out_to_pci
    && (px.out_pix >= s_reg.ovl_spix) && (px.out_pix <= s_reg.ovl_epix)
    && (px.out_line >= s_reg.ovl_sline) && (px.out_line <= s_reg.ovl_eline))
    else $error("blend outside PCI overlay window");

  // level outputs follow the frozen control word for the whole frame; the chroma key follows blending on component cycles
  a_mask_pci_only: assert property (px.busy |->
    px.mask_on == (s_reg.run.mask_bits_on && s_reg.run.pci_out))
    else $error("masking does not follow PCI output");

  a_key_needs_blend: assert property (px.comp_valid |->
    px.ckey_on == (px.blend_on && s_reg.run.color_key_on))
    else $error("chroma key does not follow blending");

  a_pick_lsb_zero: assert property (px.busy |->
    px.frac_lsb_zero == (s_reg.run.pick_then_filter && !s_reg.run.bypass))
    else $error("picking mode leaves scaling lsb live");

  a_pci_route: assert property (px.busy |-> px.out_to_pci == s_reg.run.pci_out)
    else $error("output port differs from control word");

  a_stall_no_pixels: assert property (!s_reg.permit_s2 && rgb_pci && (s_reg.state == hsc_pkg::HSC_RUN)
    |=> px.stalled && !px.comp_valid)
    else $error("RGB to PCI ran without DMA permission");

endmodule

// file: verification/hsc_host_model.sv
`timescale 1ns/10ps
// host bus unit control: holds the dma permission bit the engine waits on
module hsc_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic permit_req,
  output logic coproc_dma_permit
);
  logic permit_reg;
  assign coproc_dma_permit = permit_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      permit_reg <= 1'b0;
    end else begin
      permit_reg <= permit_req;
    end
  end
endmodule

// file: verification/tb_hsc_scaler_ctl.sv
`timescale 1ns/10ps
module tb_hsc_scaler_ctl;
  logic sys_clk;
  logic rst_n;
  logic permit_req;
  logic coproc_dma_permit;
  hsc_pkg::hsc_av_req_t av_req;
  hsc_pkg::hsc_av_rsp_t av_rsp;
  hsc_pkg::hsc_px_t px;
  hsc_pkg::hsc_px_t snap;
  hsc_pkg::hsc_ctl_t cur;
  logic [15:0] alpha_v;
  logic [15:0] cur_w;
  logic [15:0] wp0, wp1, wl0, wl1;
  logic [1:0] seq[$];
  logic [1:0] exp_q[$];
  logic [31:0] rdat;
  logic done_seen;
  logic bl;
  int fails, num_checks, cyc, first_c, last_c, n_uvr, nslots;

  hsc_host_model hsc_host_model_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .permit_req(permit_req),
    .coproc_dma_permit(coproc_dma_permit)
  );

  hsc_scaler_ctl hsc_scaler_ctl_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .av_req(av_req),
    .av_rsp(av_rsp),
    .coproc_dma_permit(coproc_dma_permit),
    .px(px)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task end_sim;
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // holds the request until waitrequest is sampled low, then releases
  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    av_req.read <= !wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 50) begin
        fails++;
        end_sim;
      end
    end while (av_rsp.waitrequest !== 1'b0);
    rdat = av_rsp.readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  // slots are sampled mid-cycle, away from the edge that updates them
  always @(negedge sys_clk) begin
    cyc++;
    if (px.frame_done === 1'b1) done_seen = 1'b1;
    if (px.comp_valid === 1'b1) begin
      if (seq.size() == 0) begin
        snap = px;
        first_c = cyc;
      end
      seq.push_back(px.comp_sel);
      last_c = cyc;
      if (px.uv_refresh === 1'b1) n_uvr++;
      bl = cur.overlay_on & cur.pci_out & (px.out_pix >= wp0) & (px.out_pix <= wp1)
        & (px.out_line >= wl0) & (px.out_line <= wl1);
      chk("blend_on", bl, px.blend_on);
      chk("ckey_on", bl & cur.color_key_on, px.ckey_on);
      chk("alpha_active", bl & (cur.overlay_pixel_format inside {2'h1, 2'h2}), px.alpha_active);
      if (cur.chroma_half_vertical_in) chk("chroma_line", px.out_line >> 1, px.chroma_line);
      chk("pix_strobe", px.comp_sel == 2'h2, px.pix_strobe);
      chk("line_end", px.pix_strobe & (px.out_pix == cur_w - 16'h0001), px.line_end);
      chk("busy", 32'h1, px.busy);
    end
  end

  task run(input logic [15:0] c, input logic [15:0] w, input logic [15:0] h);
    int n, nu;
    logic rgb;
    cur = c;
    cur_w = w;
    rgb = (cur.out_fmt >= 4'h2) && (cur.out_fmt <= 4'h7);
    av(1'b1, 5'h00, {16'h0, c});
    av(1'b1, 5'h0C, {h, w});
    seq.delete();
    exp_q.delete();
    n_uvr = 0;
    done_seen = 1'b0;
    av(1'b1, 5'h04, 32'h1);
    if (c[11] && rgb && coproc_dma_permit !== 1'b1) begin
      repeat (10) @(posedge sys_clk);
      chk("stalled", 32'h1, px.stalled);
      chk("early_slots", 32'h0, seq.size());
      av(1'b0, 5'h08, 32'h0);
      chk("status", 32'h3, rdat & 32'h3);
      permit_req <= 1'b1;
    end
    n = 0;
    while (done_seen !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) begin
        fails++;
        end_sim;
      end
    end
    repeat (2) @(posedge sys_clk);
    chk("busy_idle", 32'h0, px.busy);
    nu = 0;
    for (int l = 0; l < h; l++) begin
      for (int p = 0; p < w; p++) begin
        if (!cur.bypass && (!cur.chroma_pair_sequencing || !p[0])) begin
          exp_q.push_back(2'h0);
          exp_q.push_back(2'h1);
          nu++;
        end
        exp_q.push_back(2'h2);
      end
    end
    chk("slot_count", exp_q.size(), seq.size());
    chk("slot_span", seq.size(), last_c - first_c + 1);
    foreach (exp_q[i]) if (i < seq.size()) chk("comp_sel", exp_q[i], seq[i]);
    chk("uv_refresh", nu, n_uvr);
    chk("upscale2", rgb & !c[14] & !c[15], snap.uv_upscale2);
    chk("bypass", c[15], snap.filter_bypass);
    chk("pick", {c[9], c[9]}, {snap.tap_from_output, snap.frac_lsb_zero});
    chk("pci", c[11], snap.out_to_pci);
    chk("mask", c[10] & c[11], snap.mask_on);
    chk("endian", {c[8], c[4]}, {snap.ovl_le, snap.out_le});
    chk("formats", {c[7:6], c[3:0]}, {snap.ovl_fmt, snap.out_fmt});
    chk("reserved", c[3] | (c[7:6] == 2'h3), snap.fmt_reserved);
    chk("alpha", alpha_v, {snap.alpha1, snap.alpha0});
  endtask

  initial begin
    rst_n = 1'b0;
    permit_req = 1'b0;
    av_req = {1'b0, 1'b0, 5'h00, 32'h0, 4'hF};
    cur = 16'h0;
    alpha_v = 16'h0;
    wp0 = 16'h0;
    wp1 = 16'h0;
    wl0 = 16'h0;
    wl1 = 16'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 32; a += 2) begin
      av(1'b0, a[4:0], 32'h0);
      chk("reg_reset", 32'h0, rdat);
    end
    av(1'b1, 5'h00, 32'hFFFF8421);
    av(1'b0, 5'h00, 32'h0);
    chk("ctrl_rw", 32'h8421, rdat);
    run(16'h0802, 16'h2, 16'h1);
    run(16'h0002, 16'h4, 16'h2);
    run(16'h4002, 16'h4, 16'h2);
    run(16'h4001, 16'h3, 16'h1);
    run(16'h8000, 16'h3, 16'h1);
    run(16'h2003, 16'h1, 16'h4);
    for (int k = 0; k < 16; k++) begin
      run({3'h0, k[2], k[1], k[3], k[2], k[0], k[1:0], k[3], k[1], k[3:0]}, 16'h1, 16'h1);
    end
    wp0 = 16'h1;
    wp1 = 16'h2;
    wl0 = 16'h1;
    wl1 = 16'h1;
    alpha_v = 16'hA55A;
    av(1'b1, 5'h10, {wp1, wp0});
    av(1'b1, 5'h14, {wl1, wl0});
    av(1'b1, 5'h18, {16'h0, alpha_v});
    run(16'h5861, 16'h4, 16'h3);
    run(16'h1883, 16'h3, 16'h2);
    // abort a long frame part way: engine goes idle and emits no more slots
    cur_w = 16'h0010;
    av(1'b1, 5'h0C, 32'h0010_0010);
    av(1'b1, 5'h04, 32'h1);
    repeat (5) @(posedge sys_clk);
    av(1'b1, 5'h04, 32'h2);
    av(1'b0, 5'h08, 32'h0);
    chk("abort_status", 32'h0, rdat & 32'h1);
    nslots = seq.size();
    repeat (5) @(posedge sys_clk);
    chk("abort_quiet", nslots, seq.size());
    end_sim;
  end

  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim;
  end
endmodule
